// ---- pkg/qvm_pkg.sv ----
// quiet voltage-mode decay control: shared constants, widths and lookups
// assumes a single 25 MHz system clock; all config fields arrive as plain levels
package qvm_pkg;

   // ------------------------------------------------------------
   // clock and widths
   // ------------------------------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int US_PER_S = 1_000_000;
   localparam int HZ_PER_KHZ = 1000;
   localparam int CUR_W = 12;            // signed coil current / target width
   localparam int DUTY_W = 11;           // signed duty, magnitude in 1/1024 of a period
   localparam int DUTY_FRAC = 10;
   localparam int DUTY_MAX = 1023;
   localparam int INTEG_FRAC = 9;        // matches the integrator fraction to the largest divider, 512
   localparam int CNT_W = 11;
   localparam int HALF_W = 24;

   // ------------------------------------------------------------
   // quiet pwm rates and their period lengths
   // ------------------------------------------------------------
   localparam int PWM_KHZ_0 = 25;
   localparam int PWM_KHZ_1 = 33;
   localparam int PWM_KHZ_2 = 42;
   localparam int PWM_KHZ_3 = 50;
   localparam logic [CNT_W-1:0] PWM_PER_0 = CNT_W'(CLK_HZ / (PWM_KHZ_0 * HZ_PER_KHZ));
   localparam logic [CNT_W-1:0] PWM_PER_1 = CNT_W'(CLK_HZ / (PWM_KHZ_1 * HZ_PER_KHZ));
   localparam logic [CNT_W-1:0] PWM_PER_2 = CNT_W'(CLK_HZ / (PWM_KHZ_2 * HZ_PER_KHZ));
   localparam logic [CNT_W-1:0] PWM_PER_3 = CNT_W'(CLK_HZ / (PWM_KHZ_3 * HZ_PER_KHZ));

   // ------------------------------------------------------------
   // zero-cross sampling times
   // ------------------------------------------------------------
   localparam int SMPL_US_0 = 2;
   localparam int SMPL_US_1 = 3;
   localparam int SMPL_US_2 = 4;
   localparam int SMPL_US_3 = 5;
   localparam logic [CNT_W-1:0] SMPL_CYC_0 = CNT_W'(SMPL_US_0 * (CLK_HZ / US_PER_S));
   localparam logic [CNT_W-1:0] SMPL_CYC_1 = CNT_W'(SMPL_US_1 * (CLK_HZ / US_PER_S));
   localparam logic [CNT_W-1:0] SMPL_CYC_2 = CNT_W'(SMPL_US_2 * (CLK_HZ / US_PER_S));
   localparam logic [CNT_W-1:0] SMPL_CYC_3 = CNT_W'(SMPL_US_3 * (CLK_HZ / US_PER_S));

   // ------------------------------------------------------------
   // exit threshold: 2 Hz per count; f > thr*2 Hz <=> half_cycles*thr < limit
   // ------------------------------------------------------------
   localparam int THR_HZ_PER_CNT = 2;
   localparam logic [31:0] THR_LIMIT = 32'(CLK_HZ / (2 * THR_HZ_PER_CNT));
   localparam logic [HALF_W-1:0] HALF_SAT = {HALF_W{1'b1}};
   localparam int IDLE_CYCLES_DEF = 25_000;  // 1 ms with no step counts as standstill

   // ------------------------------------------------------------
   // gain divider codes; gain_shift maps them to right-shift amounts
   // ------------------------------------------------------------
   localparam logic [2:0] DIV_32 = 3'h0;
   localparam logic [2:0] DIV_64 = 3'h1;
   localparam logic [2:0] DIV_128 = 3'h2;
   localparam logic [2:0] DIV_256 = 3'h3;
   localparam logic [2:0] DIV_512 = 3'h4;
   localparam logic [2:0] DIV_16 = 3'h5;
   localparam logic [2:0] DIV_1 = 3'h6;

   // divider code to shift; the unused code falls back to the reset divide-by-32
   function automatic logic [3:0] gain_shift(input logic [2:0] code);
      case (code)
         DIV_64: gain_shift = 4'h6;
         DIV_128: gain_shift = 4'h7;
         DIV_256: gain_shift = 4'h8;
         DIV_512: gain_shift = 4'h9;
         DIV_16: gain_shift = 4'h4;
         DIV_1: gain_shift = 4'h0;
         default: gain_shift = 4'h5;
      endcase
   endfunction : gain_shift

   function automatic logic [CNT_W-1:0] pwm_period(input logic [1:0] sel);
      case (sel)
         2'h1: pwm_period = PWM_PER_1;
         2'h2: pwm_period = PWM_PER_2;
         2'h3: pwm_period = PWM_PER_3;
         default: pwm_period = PWM_PER_0;
      endcase
   endfunction : pwm_period

   function automatic logic [CNT_W-1:0] smpl_cycles(input logic [1:0] sel);
      case (sel)
         2'h1: smpl_cycles = SMPL_CYC_1;
         2'h2: smpl_cycles = SMPL_CYC_2;
         2'h3: smpl_cycles = SMPL_CYC_3;
         default: smpl_cycles = SMPL_CYC_0;
      endcase
   endfunction : smpl_cycles

endpackage : qvm_pkg

// ---- hdl/qvm_pi_chan.sv ----
// one coil's proportional-integral loop for quiet regulation
// assumes a synchronously released reset and sample/target on the same clock
`timescale 1ns/10ps
`default_nettype none
module qvm_pi_chan import qvm_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic update,
   input wire logic clear,
   // loop inputs
   input wire logic signed [CUR_W-1:0] target,
   input wire logic signed [CUR_W-1:0] sample,
   input wire logic [6:0] kp,
   input wire logic [6:0] ki,
   input wire logic [2:0] kp_div,
   input wire logic [2:0] ki_div,
   // loop output
   output logic signed [DUTY_W-1:0] duty
);

   typedef struct packed {
      logic signed [31:0] integ;
      logic signed [DUTY_W-1:0] duty;
   } qvm_pi_st_t;

   localparam logic signed [31:0] DUTY_LIM = 32'(DUTY_MAX);
   localparam logic signed [31:0] INTEG_LIM = 32'(DUTY_MAX) <<< INTEG_FRAC;

   qvm_pi_st_t s_q, s_d;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   // the integrator is clamped to the duty range so it cannot wind up
   always_comb begin
      logic signed [31:0] err;
      logic signed [31:0] pterm;
      logic signed [31:0] isum;
      logic signed [31:0] total;
      s_d = s_q;
      err = 32'(target) - 32'(sample);
      pterm = (err * $signed({25'h0, kp})) >>> gain_shift(kp_div);
      isum = s_q.integ + (((err * $signed({25'h0, ki})) <<< INTEG_FRAC)
             >>> gain_shift(ki_div));
      if (isum > INTEG_LIM) begin
         isum = INTEG_LIM;
      end else if (isum < -INTEG_LIM) begin
         isum = -INTEG_LIM;
      end
      total = pterm + (isum >>> INTEG_FRAC);
      if (total > DUTY_LIM) begin
         total = DUTY_LIM;
      end else if (total < -DUTY_LIM) begin
         total = -DUTY_LIM;
      end
      if (clear) begin
         s_d.integ = 32'h0000_0000;
         s_d.duty = DUTY_W'(0);
      end else if (update) begin
         s_d.integ = isum;
         s_d.duty = DUTY_W'(total);
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign duty = s_q.duty;

endmodule : qvm_pi_chan
`default_nettype wire

// ---- hdl/qvm_ctrl.sv ----
// quiet voltage-mode decay controller for two coils
// assumes config fields come from a register file on sys_clk, and that coil
// current samples and indexer targets are produced on sys_clk as well
//
// Functional notes
// - enable waits for one zero cross per coil
// - disable returns to the selected decay scheme
// - exit immediate, entry at half-cycle boundary
// - open-load check only while moving in quiet
// - stall detection off in quiet mode
// - spread spectrum off in quiet mode
// - rate field picks 25/33/42/50 kHz
// - sampling window field picks 2..5 us
// - proportional gain is 7-bit, resets zero
// - integral gain is 7-bit, resets zero
// - proportional divider code maps to divisor
// - integral divider uses the same mapping
// - exit above threshold, 2 Hz per count
// - quiet mode drives bridges by duty cycle
// - off-time setting ignored in quiet mode
`timescale 1ns/10ps
`default_nettype none
module qvm_ctrl import qvm_pkg::*; #(
   parameter int IDLE_CYCLES = IDLE_CYCLES_DEF
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // configuration
   input wire logic quiet_en,
   input wire logic [1:0] quiet_pwm_rate_sel,
   input wire logic [1:0] zero_cross_sample_time,
   input wire logic [6:0] prop_gain_raw,
   input wire logic [6:0] integ_gain_raw,
   input wire logic [2:0] prop_gain_divider,
   input wire logic [2:0] integ_gain_divider,
   input wire logic [7:0] quiet_exit_freq_threshold,
   input wire logic [2:0] decay_sel,
   input wire logic [1:0] off_time_sel,
   // feature requests from the conventional path
   input wire logic stall_det_req,
   input wire logic spread_spec_req,
   input wire logic open_load_req,
   // indexer
   input wire logic step_pulse,
   input wire logic signed [CUR_W-1:0] target_a,
   input wire logic signed [CUR_W-1:0] target_b,
   // current sense
   input wire logic signed [CUR_W-1:0] coil_a_cur,
   input wire logic signed [CUR_W-1:0] coil_b_cur,
   // mode and feature gates
   output logic quiet_active_q,
   output logic [2:0] decay_mode_q,
   output logic [1:0] off_time_q,
   output logic stall_det_en_q,
   output logic spread_spec_en_q,
   output logic open_load_en_q,
   output logic motor_moving_q,
   // bridge commands in quiet mode
   output logic bridge_a_on_q,
   output logic bridge_a_dir_q,
   output logic bridge_b_on_q,
   output logic bridge_b_dir_q
);

   typedef struct packed {
      logic [CNT_W-1:0] pwm_cnt;
      logic [1:0] rate;
      logic smpl_stb;
      logic signed [CUR_W-1:0] samp_a;
      logic signed [CUR_W-1:0] samp_b;
      logic sign_a;
      logic sign_b;
      logic crossed_a;
      logic crossed_b;
      logic [HALF_W-1:0] half_cnt;
      logic freq_high;
      logic [31:0] idle_cnt;
      logic moving;
      logic quiet;
      logic [2:0] decay_mode;
      logic [1:0] off_time;
      logic stall_en;
      logic spread_en;
      logic ol_en;
      logic br_a_on;
      logic br_a_dir;
      logic br_b_on;
      logic br_b_dir;
   } qvm_st_t;

   localparam logic [31:0] IDLE_LAST = 32'(IDLE_CYCLES - 1);

   qvm_st_t s_q, s_d;
   logic [1:0] rst_sync_q;
   logic rst_core_n;
   logic signed [DUTY_W-1:0] duty_a;
   logic signed [DUTY_W-1:0] duty_b;

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   // assert asynchronously, release two edges later so all flops leave reset together
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_core_n = rst_sync_q[1];

   // ------------------------------------------------------------
   // per-coil PI loops
   // ------------------------------------------------------------
   // loops are cleared outside quiet mode so entry always starts bumpless from zero
   qvm_pi_chan u_pi_a (
      .clk(sys_clk),
      .rst_n(rst_core_n),
      .update(s_q.smpl_stb),
      .clear(!s_q.quiet),
      .target(target_a),
      .sample(s_q.samp_a),
      .kp(prop_gain_raw),
      .ki(integ_gain_raw),
      .kp_div(prop_gain_divider),
      .ki_div(integ_gain_divider),
      .duty(duty_a)
   );

   qvm_pi_chan u_pi_b (
      .clk(sys_clk),
      .rst_n(rst_core_n),
      .update(s_q.smpl_stb),
      .clear(!s_q.quiet),
      .target(target_b),
      .sample(s_q.samp_b),
      .kp(prop_gain_raw),
      .ki(integ_gain_raw),
      .kp_div(prop_gain_divider),
      .ki_div(integ_gain_divider),
      .duty(duty_b)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic [CNT_W-1:0] period;
      logic wrap;
      logic zc_a;
      logic zc_b;
      logic [31:0] half_prod;
      logic [DUTY_W-1:0] mag_a;
      logic [DUTY_W-1:0] mag_b;
      logic [31:0] cnt_scaled;
      s_d = s_q;
      period = pwm_period(s_q.rate);
      wrap = (s_q.pwm_cnt == period - CNT_W'(1));
      half_prod = 32'(s_q.half_cnt) * 32'(quiet_exit_freq_threshold);
      // period counter; a new rate is taken only at a period end to avoid a runt pulse
      s_d.pwm_cnt = wrap ? CNT_W'(0) : s_q.pwm_cnt + CNT_W'(1);
      if (wrap) begin
         s_d.rate = quiet_pwm_rate_sel;
      end
      // one current sample per period, taken once the sampling window has passed
      s_d.smpl_stb = (s_q.pwm_cnt == smpl_cycles(zero_cross_sample_time));
      if (s_d.smpl_stb) begin
         s_d.samp_a = coil_a_cur;
         s_d.samp_b = coil_b_cur;
      end
      // zero crossings show as a sign change between consecutive samples
      zc_a = s_q.smpl_stb && (s_q.samp_a[CUR_W-1] != s_q.sign_a);
      zc_b = s_q.smpl_stb && (s_q.samp_b[CUR_W-1] != s_q.sign_b);
      if (s_q.smpl_stb) begin
         s_d.sign_a = s_q.samp_a[CUR_W-1];
         s_d.sign_b = s_q.samp_b[CUR_W-1];
      end
      // crossing flags: armed only while enabled, set wins over nothing else
      s_d.crossed_a = quiet_en && (s_q.crossed_a || zc_a);
      s_d.crossed_b = quiet_en && (s_q.crossed_b || zc_b);
      // half-cycle length of coil A against the exit threshold
      if (zc_a) begin
         // a zero threshold never counts as too fast, so quiet mode can still be entered
         s_d.freq_high = (quiet_exit_freq_threshold != 8'h00) && (half_prod < THR_LIMIT);
         s_d.half_cnt = '0;
      end else begin
         if (half_prod >= THR_LIMIT) begin
            s_d.freq_high = 1'b0;
         end
         if (s_q.half_cnt != HALF_SAT) begin
            s_d.half_cnt = s_q.half_cnt + HALF_W'(1);
         end
      end
      // standstill: no step for IDLE_CYCLES
      if (step_pulse) begin
         s_d.moving = 1'b1;
         s_d.idle_cnt = 32'h0;
      end else if (s_q.idle_cnt == IDLE_LAST) begin
         s_d.moving = 1'b0;
      end else begin
         s_d.idle_cnt = s_q.idle_cnt + 32'h1;
      end
      // mode: leave at once, enter only at a coil A half-cycle boundary
      if (s_q.quiet) begin
         if (!quiet_en || s_d.freq_high) begin
            s_d.quiet = 1'b0;
         end
      end else if (quiet_en && s_q.crossed_a && s_q.crossed_b && zc_a && !s_d.freq_high) begin
         s_d.quiet = 1'b1;
      end
      // mode-dependent gates for the conventional path
      s_d.decay_mode = decay_sel;
      if (!s_d.quiet) begin
         s_d.off_time = off_time_sel;
      end
      s_d.stall_en = stall_det_req && !s_d.quiet;
      s_d.spread_en = spread_spec_req && !s_d.quiet;
      s_d.ol_en = open_load_req && (!s_d.quiet || s_d.moving);
      // voltage-mode pwm: on time is |duty|/1024 of the period, sign gives direction
      mag_a = duty_a[DUTY_W-1] ? DUTY_W'(-duty_a) : DUTY_W'(duty_a);
      mag_b = duty_b[DUTY_W-1] ? DUTY_W'(-duty_b) : DUTY_W'(duty_b);
      cnt_scaled = 32'(s_d.pwm_cnt) << DUTY_FRAC;
      s_d.br_a_on = s_d.quiet && (cnt_scaled < 32'(mag_a) * 32'(period));
      s_d.br_b_on = s_d.quiet && (cnt_scaled < 32'(mag_b) * 32'(period));
      s_d.br_a_dir = !duty_a[DUTY_W-1];
      s_d.br_b_dir = !duty_b[DUTY_W-1];
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from state flops
   assign quiet_active_q = s_q.quiet;
   assign decay_mode_q = s_q.decay_mode;
   assign off_time_q = s_q.off_time;
   assign stall_det_en_q = s_q.stall_en;
   assign spread_spec_en_q = s_q.spread_en;
   assign open_load_en_q = s_q.ol_en;
   assign motor_moving_q = s_q.moving;
   assign bridge_a_on_q = s_q.br_a_on;
   assign bridge_a_dir_q = s_q.br_a_dir;
   assign bridge_b_on_q = s_q.br_b_on;
   assign bridge_b_dir_q = s_q.br_b_dir;

endmodule : qvm_ctrl
`default_nettype wire

// ---- tb/qvm_ctrl_props.sv ----
// qvm_ctrl port checker: mode gates, exit timing, bridge idle, standstill
// assumes it is bound into qvm_ctrl and sees only that module's ports
`timescale 1ns/10ps
`default_nettype none
module qvm_ctrl_props import qvm_pkg::*; #(
   parameter int IDLE_CYCLES = IDLE_CYCLES_DEF
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // watched inputs
   input wire logic quiet_en,
   input wire logic [2:0] decay_sel,
   input wire logic stall_det_req,
   input wire logic step_pulse,
   // watched outputs
   input wire logic quiet_active_q,
   input wire logic [2:0] decay_mode_q,
   input wire logic [1:0] off_time_q,
   input wire logic stall_det_en_q,
   input wire logic spread_spec_en_q,
   input wire logic open_load_en_q,
   input wire logic motor_moving_q,
   input wire logic bridge_a_on_q,
   input wire logic bridge_b_on_q
);
   // ----------------------------------------
   // helper counters
   // ----------------------------------------
   logic [2:0] up_q;
   logic [15:0] idle_q;
   // up_q masks the two-flop reset release, idle_q counts cycles since a step
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         up_q <= 3'h0;
         idle_q <= 16'h0;
      end else begin
         if (up_q != 3'h4) up_q <= up_q + 3'h1;
         if (step_pulse) idle_q <= 16'h0;
         else if (idle_q != 16'hFFFF) idle_q <= idle_q + 16'h1;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence s_off_seen;
      quiet_active_q && !quiet_en && up_q == 3'h4;
   endsequence
   sequence s_left;
      ##[1:2] !quiet_active_q;
   endsequence
   a_exit_prompt: assert property (s_off_seen |-> s_left)
      else $error("quiet mode kept after disable");
   a_entry_enabled: assert property ($rose(quiet_active_q) |-> $past(quiet_en) && $past(quiet_en, 2))
      else $error("quiet mode entered while disabled");
   a_stall_off: assert property (quiet_active_q |-> !stall_det_en_q)
      else $error("stall detection on in quiet mode");
   a_spread_off: assert property (quiet_active_q |-> !spread_spec_en_q)
      else $error("spread spectrum on in quiet mode");
   a_stall_follow: assert property (up_q == 3'h4 && !quiet_active_q && $past(!quiet_active_q)
      |-> stall_det_en_q == $past(stall_det_req))
      else $error("stall enable does not follow request");
   a_ol_standstill: assert property (quiet_active_q && $past(quiet_active_q) && !motor_moving_q
      && $past(!motor_moving_q) |-> !open_load_en_q)
      else $error("open-load check on at standstill");
   a_off_time_hold: assert property (quiet_active_q && $past(quiet_active_q) |-> $stable(off_time_q))
      else $error("off-time moved in quiet mode");
   a_bridge_idle: assert property (!quiet_active_q && $past(!quiet_active_q)
      |-> !bridge_a_on_q && !bridge_b_on_q)
      else $error("bridge driven outside quiet mode");
   a_decay_fwd: assert property (up_q == 3'h4 |-> decay_mode_q == $past(decay_sel))
      else $error("decay mode not forwarded");
   a_moving_rise: assert property (step_pulse && up_q == 3'h4 |-> ##[1:2] motor_moving_q)
      else $error("step not seen as motion");
   a_standstill: assert property (32'(idle_q) > IDLE_CYCLES + 2 |-> !motor_moving_q)
      else $error("motion flag stuck after idle time");
endmodule : qvm_ctrl_props
bind qvm_ctrl qvm_ctrl_props #(.IDLE_CYCLES(IDLE_CYCLES)) u_qvm_ctrl_props (.sys_clk, .rst_n, .quiet_en,
   .decay_sel, .stall_det_req, .step_pulse, .quiet_active_q, .decay_mode_q, .off_time_q, .stall_det_en_q,
   .spread_spec_en_q, .open_load_en_q, .motor_moving_q, .bridge_a_on_q, .bridge_b_on_q);
`default_nettype wire

// ---- tb/qvm_coil_model.sv ----
// two-coil current model: square-wave currents in quadrature, paced by the bench
// assumes sys_clk of the bench; freeze parks both coils at a positive level
`timescale 1ns/10ps
`default_nettype none
module qvm_coil_model import qvm_pkg::*; (
   // clock
   input wire logic sys_clk,
   // pacing
   input wire logic [31:0] half_len,
   input wire logic freeze,
   // sensed currents
   output logic signed [CUR_W-1:0] coil_a_cur,
   output logic signed [CUR_W-1:0] coil_b_cur
);
   localparam logic signed [CUR_W-1:0] AMP = 12'sh010;
   logic [31:0] ph = 32'h0;
   logic [31:0] len_q = 32'h0;
   logic pos_a = 1'b1;
   logic pos_b = 1'b1;
   // a new pace restarts the half cycle so no short interval is seen
   always @(posedge sys_clk) begin
      if (half_len != len_q || freeze) begin
         ph <= 32'h0;
         len_q <= half_len;
      end else if (ph >= half_len - 32'h1) begin
         ph <= 32'h0;
         pos_a <= !pos_a;
      end else ph <= ph + 32'h1;
      if (!freeze && ph == half_len / 2) pos_b <= !pos_b;
   end
   assign coil_a_cur = (freeze || pos_a) ? AMP : -AMP;
   assign coil_b_cur = (freeze || pos_b) ? AMP : -AMP;
endmodule : qvm_coil_model
`default_nettype wire

// ---- tb/qvm_ctrl_test.sv ----
// qvm_ctrl testbench: gating, entry and exit, pwm rate, gain dividers, speed exit
// assumes qvm_ctrl_props is bound in and qvm_coil_model stands for the coils
`timescale 1ns/10ps
`default_nettype none
module qvm_ctrl_test import qvm_pkg::*; ();
   logic sys_clk, rst_n, quiet_en, stall_det_req, spread_spec_req, open_load_req, step_pulse, freeze;
   logic [1:0] quiet_pwm_rate_sel, zero_cross_sample_time, off_time_sel, off_time_q;
   logic [6:0] prop_gain_raw, integ_gain_raw;
   logic [2:0] prop_gain_divider, integ_gain_divider, decay_sel, decay_mode_q;
   logic [7:0] quiet_exit_freq_threshold;
   logic [31:0] half_len;
   logic signed [CUR_W-1:0] target_a, target_b, coil_a_cur, coil_b_cur;
   logic quiet_active_q, stall_det_en_q, spread_spec_en_q, open_load_en_q, motor_moving_q;
   logic bridge_a_on_q, bridge_a_dir_q, bridge_b_on_q, bridge_b_dir_q;
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   int k, d, p;
   int sh[7] = '{5, 6, 7, 8, 9, 4, 0};
   int per[4] = '{PWM_PER_0, PWM_PER_1, PWM_PER_2, PWM_PER_3};

   qvm_ctrl #(.IDLE_CYCLES(20)) u_qvm_ctrl (.sys_clk, .rst_n, .quiet_en, .quiet_pwm_rate_sel,
      .zero_cross_sample_time, .prop_gain_raw, .integ_gain_raw, .prop_gain_divider, .integ_gain_divider,
      .quiet_exit_freq_threshold, .decay_sel, .off_time_sel, .stall_det_req, .spread_spec_req, .open_load_req,
      .step_pulse, .target_a, .target_b, .coil_a_cur, .coil_b_cur, .quiet_active_q, .decay_mode_q, .off_time_q,
      .stall_det_en_q, .spread_spec_en_q, .open_load_en_q, .motor_moving_q, .bridge_a_on_q, .bridge_a_dir_q,
      .bridge_b_on_q, .bridge_b_dir_q);
   qvm_coil_model u_qvm_coil_model (.sys_clk, .half_len, .freeze, .coil_a_cur, .coil_b_cur);

   // ----------------------------------------
   // clock, timeout and shared tasks
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // ceiling well above the longest path through the tests
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 99000) begin
         failures++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      if (failures == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc
   // bounded wait for the mode flag, then sample it settled
   task automatic wait_quiet(input logic lvl, input int lim);
      for (int n = 0; n < lim && quiet_active_q !== lvl; n++) @(posedge sys_clk);
      #1;
   endtask : wait_quiet
   // counts bridge-on cycles over one window; duty must stand still meanwhile
   task automatic count_on(input int w, output int on);
      on = 0;
      repeat (w) begin
         @(posedge sys_clk);
         #1;
         on += int'(bridge_a_on_q === 1'b1);
      end
   endtask : count_on

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {rst_n, quiet_en, step_pulse, prop_gain_raw, integ_gain_raw, prop_gain_divider} = '0;
      {quiet_pwm_rate_sel, off_time_sel, decay_sel, integ_gain_divider} = '0;
      {stall_det_req, spread_spec_req, open_load_req, freeze} = 4'hF;
      zero_cross_sample_time = 2'h3;
      quiet_exit_freq_threshold = 8'h00; // zero never leaves on speed
      half_len = 32'd2000;
      target_a = 12'sh110; // sits 256 above the parked coil level
      target_b = 12'sh110;
      cyc(3);
      rst_n <= 1'b1;
      cyc(4);
      // forwarding outside quiet mode, every decay code
      for (int i = 0; i < 8; i++) begin
         decay_sel <= 3'(i);
         off_time_sel <= 2'(i);
         cyc(2);
         #1;
         check("decay_mode", 16'(decay_mode_q), 16'(i));
         check("off_time", 16'(off_time_q), 16'(i & 3));
      end
      check("gates", {stall_det_en_q, spread_spec_en_q, open_load_en_q}, 16'h7);
      // enabled but coils parked: no zero cross, no entry
      quiet_en <= 1'b1;
      cyc(300);
      #1;
      check("quiet_parked", 16'(quiet_active_q), 16'h0);
      freeze <= 1'b0;
      wait_quiet(1'b1, 12000);
      check("quiet_entry", 16'(quiet_active_q), 16'h1);
      check("gates_quiet", {stall_det_en_q, spread_spec_en_q}, 16'h0);
      freeze <= 1'b1;
      off_time_sel <= 2'h1;
      cyc(40);
      #1;
      check("off_time_held", 16'(off_time_q), 16'h3);
      check("ol_still", 16'(open_load_en_q), 16'h0);
      step_pulse <= 1'b1;
      cyc(1);
      step_pulse <= 1'b0;
      cyc(3);
      #1;
      check("ol_moving", {motor_moving_q, open_load_en_q}, 16'h3);
      // zero gains give zero duty
      count_on(1000, k);
      check("duty_zero", 16'(k), 16'h0);
      // duty 512 at every rate: on cycles = ceil(512*p/1024)
      prop_gain_raw <= 7'h40;
      for (int r = 0; r < 4; r++) begin
         quiet_pwm_rate_sel <= 2'(r);
         cyc(1100);
         p = per[r];
         count_on(p, k);
         check("rate_on", 16'(k), 16'((512 * p + 1023) / 1024));
      end
      check("dir_a", 16'(bridge_a_dir_q), 16'h1);
      check("dir_b", 16'(bridge_b_dir_q), 16'h1);
      // divider codes 0 to 6 at the 50 kHz rate
      for (int c = 0; c < 7; c++) begin
         prop_gain_divider <= 3'(c);
         cyc(1100);
         d = (16384 >> sh[c]) > 1023 ? 1023 : 16384 >> sh[c];
         count_on(500, k);
         check("kp_div_on", 16'(k), 16'((d * 500 + 1023) / 1024));
      end
      prop_gain_raw <= 7'h00;
      integ_gain_raw <= 7'h7F;
      integ_gain_divider <= 3'h6;
      cyc(1100);
      count_on(500, k);
      check("ki_sat_on", 16'(k), 16'd500);
      // disable: immediate exit, then re-enable must re-cross
      quiet_en <= 1'b0;
      cyc(3);
      #1;
      check("exit", {quiet_active_q, stall_det_en_q, bridge_a_on_q}, 16'h2);
      quiet_en <= 1'b1;
      cyc(300);
      #1;
      check("no_reentry", 16'(quiet_active_q), 16'h0);
      // 6250 Hz coil current arms both crossings but is above 502 Hz, so no entry yet
      quiet_exit_freq_threshold <= 8'd251;
      freeze <= 1'b0;
      cyc(5000);
      #1;
      check("fast_no_entry", 16'(quiet_active_q), 16'h0);
      // 500 Hz coil current: 251 counts (502 Hz) keeps quiet, 249 counts leaves
      half_len <= 32'd25000;
      wait_quiet(1'b1, 30000);
      check("below_thr", 16'(quiet_active_q), 16'h1);
      quiet_exit_freq_threshold <= 8'd249;
      wait_quiet(1'b0, 26000);
      check("above_thr", 16'(quiet_active_q), 16'h0);
      give_verdict();
   end
endmodule : qvm_ctrl_test
`default_nettype wire
